// >>> logic/tlca_pkg.sv
// constants, register map and types shared by the temperature limit compare and alert block
package tlca_pkg;

	// clock and bus-low timeout
	localparam int CLK_HZ = 25_000_000;
	localparam int TIMEOUT_MIN_MS = 25;
	localparam int TIMEOUT_MAX_MS = 35;
	localparam int TIMEOUT_CYCLES = (CLK_HZ / 1000) * TIMEOUT_MIN_MS;
	localparam int TIMEOUT_CNT_W = 20;

	// register port widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// register offsets
	localparam logic [7:0] REG_LOCAL_MSB = 8'h00;
	localparam logic [7:0] REG_LOCAL_LSB = 8'h01;
	localparam logic [7:0] REG_STATUS1 = 8'h02;
	localparam logic [7:0] REG_CONFIG1 = 8'h03;
	localparam logic [7:0] REG_REM_SGN_MSB = 8'h04;
	localparam logic [7:0] REG_REM_SGN_LSB = 8'h05;
	localparam logic [7:0] REG_REM_UNS_MSB = 8'h06;
	localparam logic [7:0] REG_REM_UNS_LSB = 8'h07;
	localparam logic [7:0] REG_CONFIG2 = 8'h08;
	localparam logic [7:0] REG_REM_CRIT_LIM = 8'h09;
	localparam logic [7:0] REG_REM_OS_LIM = 8'h0a;
	localparam logic [7:0] REG_LOC_LIM = 8'h0b;
	localparam logic [7:0] REG_ONE_SHOT = 8'h0c;

	// first configuration register fields
	localparam int CFG1_REM_OS_MASK = 0;
	localparam int CFG1_REM_CRIT_MASK = 1;
	localparam int CFG1_LOC_OS_MASK = 2;
	localparam int CFG1_LOC_CRIT_MASK = 3;
	localparam int CFG1_STANDBY = 6;
	localparam logic [7:0] CFG1_WR_MASK = 8'h4f;

	// second configuration register fields
	localparam int CFG2_W = 5;
	localparam int CFG2_FILTER_CFG_LO = 1;
	localparam int CFG2_FILTER_CFG_HI = 2;

	// status register fields
	localparam int STAT_REM_OS_HIT = 0;
	localparam int STAT_REM_CRIT_HIT = 1;
	localparam int STAT_LOC_HIT = 2;
	localparam int STAT_BUSY = 7;

	// values after reset
	localparam logic [7:0] CFG1_RESET = 8'h00;
	localparam logic [CFG2_W-1:0] CFG2_RESET = 5'h1f;
	localparam logic [6:0] LOC_LIM_RESET = 7'h55;
	localparam logic [7:0] REM_CRIT_LIM_RESET = 8'h6e;
	localparam logic [7:0] REM_OS_LIM_RESET = 8'h55;
	localparam logic [10:0] LOCAL_TEMP_RESET = 11'h000;
	localparam logic [12:0] REM_TEMP_RESET = 13'h0000;

	// conversion sequencer
	typedef enum logic [1:0] {CV_IDLE, CV_START, CV_WAIT, CV_UPDATE} tlca_conv_t;

endpackage

// >>> logic/tlca_core.sv
// digital side of a two-channel temperature monitor: formatting, limit compare, alerts, standby, bus timeout
`timescale 1ns/1ps

module tlca_core
	import tlca_pkg::*;
#(
	parameter int TIMEOUT_CYC = TIMEOUT_CYCLES
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// register port
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	output logic [DATA_W-1:0] regRdData,
	// converter front end, same clock
	output logic convStart,
	input wire logic convDone,
	input wire logic [10:0] localTempIn,
	input wire logic [13:0] remoteRawIn,
	input wire logic [13:0] remoteFiltIn,
	// serial bus lines and serial engine
	input wire logic smbClkIn,
	input wire logic smbDataIn,
	input wire logic smbDataDriveReq,
	output logic smbDataOe,
	output logic busTimeoutReset,
	// open-drain alerts, enable high pulls the pin low
	output logic criticalAlertOutOe,
	output logic overtempAlertOutOe
);

	// clamp a signed 1/32 degree reading into the unsigned 0..255.97 form
	function automatic logic [12:0] toUnsigned(input logic [13:0] v);
		toUnsigned = v[13] ? 13'h0000 : v[12:0];
	endfunction

	// clamp into the signed -128..127.97 form
	function automatic logic [12:0] toSigned(input logic [13:0] v);
		if (!v[13] && v[12])
			toSigned = 13'h0fff;
		else if (v[13] && !v[12])
			toSigned = 13'h1000;
		else
			toSigned = v[12:0];
	endfunction

	logic [7:0] cfg1_reg;
	logic [CFG2_W-1:0] cfg2_reg;
	logic [6:0] locLim_reg;
	logic [7:0] remCritLim_reg;
	logic [7:0] remOsLim_reg;
	logic [10:0] localTemp_reg;
	logic [12:0] remUns_reg;
	logic [12:0] remSgn_reg;
	logic locHit_reg;
	logic remCritHit_reg;
	logic remOsHit_reg;
	logic oneShotPend_reg;
	tlca_conv_t state_reg;
	tlca_conv_t state_next;
	logic convStart_reg;
	logic [DATA_W-1:0] regRdData_reg;
	logic smbClkMeta_reg;
	logic smbClkSync_reg;
	logic smbDataMeta_reg;
	logic smbDataSync_reg;
	logic [TIMEOUT_CNT_W-1:0] lowCnt_reg;
	logic timedOut_reg;
	logic busTimeoutReset_reg;
	logic smbDataOe_reg;
	logic critOe_reg;
	logic osOe_reg;

	logic filterOn;
	logic standby;
	logic [13:0] remSel;
	logic [13:0] remUse;
	logic locExceeds;
	logic remCritExceeds;
	logic remOsExceeds;
	logic oneShotWr;
	logic roundBegins;
	logic critNext;
	logic osNext;

	assign filterOn = cfg2_reg[CFG2_FILTER_CFG_HI] & cfg2_reg[CFG2_FILTER_CFG_LO];
	assign standby = cfg1_reg[CFG1_STANDBY];
	assign remSel = filterOn ? remoteFiltIn : remoteRawIn;
	assign remUse = filterOn ? remSel : {remSel[13:2], 2'b00};
	assign oneShotWr = regWrStb && (regAddr == REG_ONE_SHOT);
	assign roundBegins = (state_reg == CV_IDLE) && (!standby || oneShotPend_reg);

	// limit is unsigned whole degrees; readings carry fraction bits, so exceed means strictly above
	assign locExceeds = $signed(localTemp_reg) > $signed({1'b0, locLim_reg, 3'b000});
	assign remCritExceeds = remUns_reg > {remCritLim_reg, 5'b00000};
	assign remOsExceeds = remUns_reg > {remOsLim_reg, 5'b00000};

	assign critNext = (locHit_reg & ~cfg1_reg[CFG1_LOC_CRIT_MASK])
		| (remCritHit_reg & ~cfg1_reg[CFG1_REM_CRIT_MASK]);
	assign osNext = (locHit_reg & ~cfg1_reg[CFG1_LOC_OS_MASK])
		| (remOsHit_reg & ~cfg1_reg[CFG1_REM_OS_MASK]);

	// software-written registers
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			cfg1_reg <= CFG1_RESET;
			cfg2_reg <= CFG2_RESET;
			locLim_reg <= LOC_LIM_RESET;
			remCritLim_reg <= REM_CRIT_LIM_RESET;
			remOsLim_reg <= REM_OS_LIM_RESET;
		end else if (regWrStb) begin
			case (regAddr)
				REG_CONFIG1: cfg1_reg <= regWrData & CFG1_WR_MASK;
				REG_CONFIG2: cfg2_reg <= regWrData[CFG2_W-1:0];
				REG_LOC_LIM: locLim_reg <= regWrData[6:0];
				REG_REM_CRIT_LIM: remCritLim_reg <= regWrData;
				REG_REM_OS_LIM: remOsLim_reg <= regWrData;
				default: ;
			endcase
		end
	end

	// one-shot request; a write landing as the round starts is kept, the data is dropped
	always_ff @(posedge ref_clk) begin
		if (!reset_n)
			oneShotPend_reg <= 1'b0;
		else if (oneShotWr && standby)
			oneShotPend_reg <= 1'b1;
		else if (roundBegins)
			oneShotPend_reg <= 1'b0;
	end

	// conversion sequencer
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			CV_IDLE: if (roundBegins) state_next = CV_START;
			CV_START: state_next = CV_WAIT;
			CV_WAIT: if (convDone) state_next = CV_UPDATE;
			CV_UPDATE: state_next = CV_IDLE;
			default: state_next = CV_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			state_reg <= CV_IDLE;
			convStart_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			convStart_reg <= roundBegins;
		end
	end

	// results only change at completion, so reads always see the last finished round
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			localTemp_reg <= LOCAL_TEMP_RESET;
			remUns_reg <= REM_TEMP_RESET;
			remSgn_reg <= REM_TEMP_RESET;
		end else if (state_reg == CV_WAIT && convDone) begin
			localTemp_reg <= localTempIn;
			remUns_reg <= toUnsigned(remUse);
			// the positive clamp sets the low bits, so they are cut again while the filter is off
			remSgn_reg <= toSigned(remUse) & {11'h7ff, filterOn, filterOn};
		end
	end

	// comparisons refresh once per completed round
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			locHit_reg <= 1'b0;
			remCritHit_reg <= 1'b0;
			remOsHit_reg <= 1'b0;
		end else if (state_reg == CV_UPDATE) begin
			locHit_reg <= locExceeds;
			remCritHit_reg <= remCritExceeds;
			remOsHit_reg <= remOsExceeds;
		end
	end

	// alert pins
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			critOe_reg <= 1'b0;
			osOe_reg <= 1'b0;
		end else begin
			critOe_reg <= critNext;
			osOe_reg <= osNext;
		end
	end

	// register reads, data in the following cycle only
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			regRdData_reg <= 8'h00;
		end else if (regRdStb) begin
			case (regAddr)
				REG_LOCAL_MSB: regRdData_reg <= localTemp_reg[10:3];
				REG_LOCAL_LSB: regRdData_reg <= {localTemp_reg[2:0], 5'b00000};
				REG_STATUS1: regRdData_reg <= {state_reg != CV_IDLE, 4'h0, locHit_reg,
					remCritHit_reg, remOsHit_reg};
				REG_CONFIG1: regRdData_reg <= cfg1_reg;
				REG_REM_SGN_MSB: regRdData_reg <= remSgn_reg[12:5];
				REG_REM_SGN_LSB: regRdData_reg <= {remSgn_reg[4:0], 3'b000};
				REG_REM_UNS_MSB: regRdData_reg <= remUns_reg[12:5];
				REG_REM_UNS_LSB: regRdData_reg <= {remUns_reg[4:0], 3'b000};
				REG_CONFIG2: regRdData_reg <= {3'b000, cfg2_reg};
				REG_REM_CRIT_LIM: regRdData_reg <= remCritLim_reg;
				REG_REM_OS_LIM: regRdData_reg <= remOsLim_reg;
				REG_LOC_LIM: regRdData_reg <= {1'b0, locLim_reg};
				default: regRdData_reg <= 8'h00;
			endcase
		end else begin
			regRdData_reg <= 8'h00;
		end
	end

	// bus line synchronisers
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			smbClkMeta_reg <= 1'b1;
			smbClkSync_reg <= 1'b1;
			smbDataMeta_reg <= 1'b1;
			smbDataSync_reg <= 1'b1;
		end else begin
			smbClkMeta_reg <= smbClkIn;
			smbClkSync_reg <= smbClkMeta_reg;
			smbDataMeta_reg <= smbDataIn;
			smbDataSync_reg <= smbDataMeta_reg;
		end
	end

	// bus-low watchdog; fires at the 25 ms minimum and holds the bus released until both lines go high
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			lowCnt_reg <= '0;
			timedOut_reg <= 1'b0;
			busTimeoutReset_reg <= 1'b0;
		end else if (smbClkSync_reg && smbDataSync_reg) begin
			lowCnt_reg <= '0;
			timedOut_reg <= 1'b0;
			busTimeoutReset_reg <= 1'b0;
		end else if (!timedOut_reg && lowCnt_reg == TIMEOUT_CNT_W'(TIMEOUT_CYC - 1)) begin
			timedOut_reg <= 1'b1;
			busTimeoutReset_reg <= 1'b1;
		end else begin
			if (!timedOut_reg)
				lowCnt_reg <= lowCnt_reg + 1'b1;
			busTimeoutReset_reg <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n)
			smbDataOe_reg <= 1'b0;
		else
			smbDataOe_reg <= smbDataDriveReq && !timedOut_reg && !busTimeoutReset_reg;
	end

	assign regRdData = regRdData_reg;
	assign convStart = convStart_reg;
	assign smbDataOe = smbDataOe_reg;
	assign busTimeoutReset = busTimeoutReset_reg;
	assign criticalAlertOutOe = critOe_reg;
	assign overtempAlertOutOe = osOe_reg;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	a_local_limit_hit: assert property ((state_reg == CV_UPDATE) |=> (locHit_reg == $past(locExceeds)))
		else $error("local compare result not captured at round end");

	a_crit_local_mask: assert property ((locHit_reg && !cfg1_reg[CFG1_LOC_CRIT_MASK])
		|=> criticalAlertOutOe)
		else $error("unmasked local hit did not pull critical alert");

	a_os_remote_feed: assert property ((!remOsHit_reg && !locHit_reg) |=> !overtempAlertOutOe)
		else $error("overtemp alert asserted without a feeding hit");

	a_crit_remote_mask: assert property ((remCritHit_reg && cfg1_reg[CFG1_REM_CRIT_MASK] && !locHit_reg)
		|=> !criticalAlertOutOe)
		else $error("masked remote critical hit reached the pin");

	a_status_read_back: assert property ((regRdStb && regAddr == REG_STATUS1)
		|=> regRdData[2:0] == $past({locHit_reg, remCritHit_reg, remOsHit_reg}))
		else $error("status read does not show compare results");

	a_filter_off_lsbs: assert property ((!filterOn && state_reg == CV_WAIT && convDone)
		|=> remUns_reg[1:0] == 2'b00 && remSgn_reg[1:0] == 2'b00)
		else $error("remote low bits nonzero with filter off");

	a_standby_halts: assert property ((standby && !oneShotPend_reg && state_reg == CV_IDLE && !oneShotWr)
		|=> !convStart && state_reg == CV_IDLE)
		else $error("conversion started in standby without one-shot");

	a_one_shot_round: assert property ((oneShotWr && standby && state_reg == CV_IDLE)
		|=> ##[0:2] convStart)
		else $error("one-shot write did not start a round");

	a_temp_read_msb: assert property ((regRdStb && regAddr == REG_LOCAL_MSB)
		|=> regRdData == $past(localTemp_reg[10:3]))
		else $error("local temperature read returned wrong byte");

	a_timeout_release: assert property (timedOut_reg |=> !smbDataOe)
		else $error("data line driven after bus timeout");

	a_crit_remote_feed: assert property ((!remCritHit_reg && !locHit_reg) |=> !criticalAlertOutOe)
		else $error("critical alert asserted without a feeding hit");

	a_os_local_mask: assert property ((locHit_reg && !cfg1_reg[CFG1_LOC_OS_MASK]) |=> overtempAlertOutOe)
		else $error("unmasked local hit did not pull overtemp alert");

	a_remote_hit_capture: assert property ((state_reg == CV_UPDATE)
		|=> (remCritHit_reg == $past(remCritExceeds) && remOsHit_reg == $past(remOsExceeds)))
		else $error("remote compare results not captured at round end");

	a_timeout_one_pulse: assert property (busTimeoutReset |=> !busTimeoutReset)
		else $error("bus reset pulse longer than one cycle");

endmodule // tlca_core

// >>> testbench/tlca_front_model.sv
// behavioural converter front end that answers each round request with one set of readings
`timescale 1ns/1ps

module tlca_front_model #(
	parameter int DELAY = 10
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// round handshake
	input wire logic convStart,
	output logic convDone,
	// readings chosen by the bench
	input wire logic [10:0] localSet,
	input wire logic [13:0] rawSet,
	input wire logic [13:0] filtSet,
	// readings seen by the block
	output logic [10:0] localTempIn,
	output logic [13:0] remoteRawIn,
	output logic [13:0] remoteFiltIn
);
	int cnt;

	always @(posedge ref_clk) begin
		if (!reset_n) begin
			cnt <= 0;
			convDone <= 1'b0;
		end else begin
			convDone <= (cnt == 1);
			if (convStart)
				cnt <= DELAY;
			else if (cnt != 0)
				cnt <= cnt - 1;
		end
	end

	// readings are only valid in the done cycle; scrambled elsewhere so late sampling shows up
	assign localTempIn = convDone ? localSet : ~localSet;
	assign remoteRawIn = convDone ? rawSet : ~rawSet;
	assign remoteFiltIn = convDone ? filtSet : ~filtSet;
endmodule // tlca_front_model

// >>> testbench/tb.sv
// self-checking bench for the temperature limit compare and alert block
`timescale 1ns/1ps

module tb
	import tlca_pkg::*;
;
	logic ref_clk, reset_n, regWrStb, regRdStb, convStart, convDone;
	logic [7:0] regAddr, regWrData, regRdData;
	logic [10:0] localTempIn, localSet;
	logic [13:0] remoteRawIn, remoteFiltIn, rawSet, filtSet;
	logic smbClkIn, smbDataIn, smbDataDriveReq, smbDataOe, busTimeoutReset;
	logic criticalAlertOutOe, overtempAlertOutOe;
	int err_count, samples_checked, n;
	int startCnt = 0;
	int toCnt = 0;

	tlca_core #(.TIMEOUT_CYC(50)) tlca_core_inst (.ref_clk(ref_clk), .reset_n(reset_n), .regAddr(regAddr),
		.regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
		.convStart(convStart), .convDone(convDone), .localTempIn(localTempIn), .remoteRawIn(remoteRawIn),
		.remoteFiltIn(remoteFiltIn), .smbClkIn(smbClkIn), .smbDataIn(smbDataIn),
		.smbDataDriveReq(smbDataDriveReq), .smbDataOe(smbDataOe), .busTimeoutReset(busTimeoutReset),
		.criticalAlertOutOe(criticalAlertOutOe), .overtempAlertOutOe(overtempAlertOutOe));

	tlca_front_model tlca_front_model_inst (.ref_clk(ref_clk), .reset_n(reset_n), .convStart(convStart),
		.convDone(convDone), .localSet(localSet), .rawSet(rawSet), .filtSet(filtSet),
		.localTempIn(localTempIn), .remoteRawIn(remoteRawIn), .remoteFiltIn(remoteFiltIn));

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		if (convStart === 1'b1)
			startCnt <= startCnt + 1;
		if (busTimeoutReset === 1'b1)
			toCnt <= toCnt + 1;
	end

	task automatic print_verdict();
		$display("checked %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regWrStb <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge ref_clk);
		regWrStb <= 1'b0;
	endtask

	// status reads mask off the busy bit, which depends on where the sequencer happens to be
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
		@(posedge ref_clk);
		regRdStb <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRdStb <= 1'b0;
		#1;
		chk({8'h00, regRdData & m}, {8'h00, e});
	endtask

	task automatic rnd();
		for (int i = 0; i < 80; i++) begin
			@(posedge ref_clk);
			#1;
			if (convDone === 1'b1)
				break;
		end
		chk({15'h0000, convDone}, 16'h0001);
		repeat (4) @(posedge ref_clk);
	endtask

	task automatic alerts(input logic ec, input logic eo);
		#1;
		chk({14'h0000, criticalAlertOutOe, overtempAlertOutOe}, {14'h0000, ec, eo});
	endtask

	task automatic mask(input logic [7:0] c, input logic ec, input logic eo);
		wr(8'h03, c);
		rnd();
		alerts(ec, eo);
	endtask

	initial begin
		repeat (5000) @(posedge ref_clk);
		err_count++;
		print_verdict();
	end

	initial begin
		err_count = 0;
		samples_checked = 0;
		reset_n = 1'b0;
		regWrStb = 1'b0;
		regRdStb = 1'b0;
		regAddr = 8'h00;
		regWrData = 8'h00;
		smbClkIn = 1'b1;
		smbDataIn = 1'b1;
		smbDataDriveReq = 1'b0;
		localSet = 11'h2a9;
		rawSet = 14'h0640;
		filtSet = 14'h0640;
		repeat (2) @(posedge ref_clk);
		reset_n <= 1'b1;
		rdchk(8'h03, 8'h00);
		rdchk(8'h08, 8'h1f);
		rdchk(8'h09, 8'h6e);
		rdchk(8'h0a, 8'h55);
		rdchk(8'h0b, 8'h55);
		rnd();
		alerts(1'b1, 1'b1);
		rdchk(8'h00, 8'h55);
		rdchk(8'h01, 8'h20);
		rdchk(8'h02, 8'h04, 8'h07);
		mask(8'h08, 1'b0, 1'b1);
		mask(8'h04, 1'b1, 1'b0);
		localSet <= 11'h2a8;
		rawSet <= 14'h0c83;
		filtSet <= 14'h0f03;
		mask(8'h00, 1'b1, 1'b1);
		mask(8'h02, 1'b0, 1'b1);
		mask(8'h01, 1'b1, 1'b0);
		mask(8'h0f, 1'b0, 1'b0);
		rdchk(8'h02, 8'h03, 8'h07);
		rdchk(8'h04, 8'h78);
		rdchk(8'h05, 8'h18);
		rdchk(8'h06, 8'h78);
		rdchk(8'h07, 8'h18);
		wr(8'h08, 8'h00);
		rnd();
		rdchk(8'h04, 8'h64);
		rdchk(8'h05, 8'h00);
		rdchk(8'h02, 8'h01, 8'h07);
		rawSet <= 14'h3f03;
		wr(8'h08, 8'h04);
		rnd();
		rdchk(8'h06, 8'h00);
		rdchk(8'h04, 8'hf8);
		rdchk(8'h05, 8'h00);
		rawSet <= 14'h0c83;
		wr(8'h0b, 8'hff);
		rdchk(8'h0b, 8'h7f);
		wr(8'h09, 8'hff);
		rdchk(8'h09, 8'hff);
		wr(8'h0a, 8'h64);
		rnd();
		rdchk(8'h02, 8'h00, 8'h07);
		localSet <= 11'h0f0;
		rdchk(8'h00, 8'h55);
		rnd();
		rdchk(8'h00, 8'h1e);
		wr(8'h0b, 8'h55);
		wr(8'h03, 8'h40);
		repeat (30) @(posedge ref_clk);
		n = startCnt;
		repeat (100) @(posedge ref_clk);
		chk(startCnt[15:0], n[15:0]);
		rdchk(8'h03, 8'h40);
		localSet <= 11'h2a9;
		wr(8'h0c, 8'h5a);
		repeat (40) @(posedge ref_clk);
		alerts(1'b1, 1'b1);
		chk(startCnt[15:0], n[15:0] + 16'h0001);
		@(posedge ref_clk);
		smbDataDriveReq <= 1'b1;
		repeat (5) @(posedge ref_clk);
		#1;
		chk({15'h0000, smbDataOe}, 16'h0001);
		@(posedge ref_clk);
		smbClkIn <= 1'b0;
		repeat (40) @(posedge ref_clk);
		#1;
		chk(toCnt[15:0], 16'h0000);
		repeat (30) @(posedge ref_clk);
		#1;
		chk(toCnt[15:0], 16'h0001);
		chk({15'h0000, smbDataOe}, 16'h0000);
		@(posedge ref_clk);
		smbClkIn <= 1'b1;
		repeat (10) @(posedge ref_clk);
		#1;
		chk({15'h0000, smbDataOe}, 16'h0001);
		print_verdict();
	end
endmodule // tb
